/* rtl/itrp_pkg.sv */
package itrp_pkg;

  // Byte framing on the link
  localparam int unsigned   BYTE_BITS      = 8;
  localparam logic [3:0]    BIT_CNT_LAST   = 4'h8;
  localparam logic [3:0]    TX_CNT_LAST    = 4'h7;

  // Reserved soft-reset call and its two key bytes
  localparam logic [6:0]    SRST_ADDR      = 7'h6B;
  localparam logic [7:0]    SRST_KEY1      = 8'hA5;
  localparam logic [7:0]    SRST_KEY2      = 8'h5A;

  // Pointer/control byte layout and value after reset
  localparam logic [7:0]    CTRL_RST       = 8'h00;
  localparam int unsigned   CTRL_EN_POS    = 7;
  localparam int unsigned   CTRL_CODE_HI   = 7;
  localparam int unsigned   CTRL_CODE_LO   = 5;
  localparam int unsigned   CTRL_PTR_HI    = 4;
  localparam int unsigned   CTRL_PTR_LO    = 0;

  // Register pointer landmarks
  localparam logic [4:0]    PTR_FIRST      = 5'h00;
  localparam logic [4:0]    PTR_LAST       = 5'h1B;
  localparam logic [4:0]    PTR_BRIGHT_LO  = 5'h02;
  localparam logic [4:0]    PTR_BRIGHT_HI  = 5'h11;
  localparam logic [4:0]    PTR_GLOBAL_LO  = 5'h12;
  localparam logic [4:0]    PTR_GLOBAL_HI  = 5'h13;

  // Auto-increment option codes
  localparam logic [2:0]    AUTOINC_FIXED  = 3'h0;
  localparam logic [2:0]    AUTOINC_ALL    = 3'h4;
  localparam logic [2:0]    AUTOINC_BRIGHT = 3'h5;
  localparam logic [2:0]    AUTOINC_GLOBAL = 3'h6;
  localparam logic [2:0]    AUTOINC_BOTH   = 3'h7;

  // Idle level of the bus lines, used as synchroniser reset value
  localparam logic [1:0]    BUS_IDLE       = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX     = 3'b011,
    ST_TX_ACK = 3'b100
  } itrp_link_st_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_CTRL = 2'b01,
    PH_DATA = 2'b10
  } itrp_phase_t;

  typedef enum logic [1:0] {
    SR_NONE  = 2'b00,
    SR_ADDR  = 2'b01,
    SR_KEY1  = 2'b10,
    SR_ARMED = 2'b11
  } itrp_srst_t;

endpackage : itrp_pkg

/* rtl/itrp_sync.sv */
`timescale 1ns/10ps
module itrp_sync #(
  parameter int unsigned     W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic          clk_i,  // Destination clock
  input  wire logic          rstn_i, // Async reset, active low
  input  wire logic [W-1:0]  d_i,    // Foreign-domain level
  output logic      [W-1:0]  q_o     // Synchronised level
);

  logic [W-1:0] meta_q;

  // Two flops; the first is read only by the second
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= RST_VAL;
      q_o    <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule : itrp_sync

/* rtl/itrp_ptr_next.sv */
`timescale 1ns/10ps
module itrp_ptr_next
  import itrp_pkg::*;
(
  input  wire logic [2:0] code_i, // Auto-increment enable and option
  input  wire logic [4:0] ptr_i,  // Pointer just accessed
  output logic      [4:0] ptr_o   // Pointer for the next byte
);

  logic [4:0] lim;
  logic [4:0] wrap;

  // Limit and landing point per option code
  always_comb begin
    lim  = PTR_LAST;
    wrap = PTR_FIRST;
    case (code_i)
      AUTOINC_BRIGHT: begin
        lim  = PTR_BRIGHT_HI;
        wrap = PTR_BRIGHT_LO;
      end
      AUTOINC_GLOBAL: begin
        lim  = PTR_GLOBAL_HI;
        wrap = PTR_GLOBAL_LO;
      end
      AUTOINC_BOTH: begin
        lim  = PTR_GLOBAL_HI;
        wrap = PTR_BRIGHT_LO;
      end
      default: begin
        lim  = PTR_LAST;
        wrap = PTR_FIRST;
      end
    endcase
  end

  // Reserved codes have the enable clear and so hold the pointer
  always_comb begin
    if (!code_i[2]) begin
      ptr_o = ptr_i;
    end else if (ptr_i == lim) begin
      ptr_o = wrap;
    end else if (ptr_i == PTR_LAST) begin
      ptr_o = PTR_FIRST;
    end else begin
      ptr_o = ptr_i + 5'h01;
    end
  end

endmodule : itrp_ptr_next

/* rtl/itrp_i2c_target.sv */
`timescale 1ns/10ps
// Summary of operation
// - Soft-reset call is acknowledged only with write direction.
// - Soft-reset address never matches own, group or sub-call address.
// - One bit per clock pulse; data changes with clock high are control.
// - Data falling while clock high is START.
// - Data rising while clock high is STOP.
// - Eight bits plus acknowledge per byte, any number of bytes.
// - Target pulls data low through the acknowledge clock of each byte it accepts.
// - After a not-acknowledged read byte the target releases data.
// - First written byte after an accepted address other than the soft-reset call is the control byte.
// - Control low five bits are pointer, top three auto-increment.
// - First data access uses the pointer; legal pointers 00 to 1B.
// - Enable set advances pointer after every data byte.
// - Option 000 keeps the pointer fixed.
// - Option 100 walks all registers, 1B wraps to 00.
// - Option 101 walks brightness registers, 11 wraps to 02.
// - Option 110 walks global registers, 13 wraps to 12.
// - Option 111 walks brightness and global, 13 wraps to 02.
// - Increment changes only pointer bits, option bits are kept.
// - Pointer above the limit runs to 1B, wraps to 00, then cycles.
// - Soft-reset call address is 1101011 with write direction.
// - Soft reset needs keys A5 then 5A, then STOP resets defaults.
// - 02 to 11 are brightness, 12 and 13 the global range.
module itrp_i2c_target
  import itrp_pkg::*;
#(
  parameter logic [2:0] OWN_ADDR_HI = 3'h6  // Fixed upper address bits
) (
  input  wire logic       clk_i,           // System clock
  input  wire logic       rstn_i,          // Async reset, active low
  input  wire logic       link_clk_i,      // Link sampling clock
  input  wire logic       scl_i,           // Bus clock line level
  input  wire logic       sda_i,           // Bus data line level
  output logic            sda_o,           // Data line drive value
  output logic            sda_oen_o,       // Data drive enable, low=drive
  input  wire logic [3:0] addr_pins_i,     // Hardware address straps
  input  wire logic       group_call_enable_i, // All-call address on
  input  wire logic [6:0] group_call_addr_i, // All-call address
  input  wire logic [2:0] sub_enable_i,    // Sub-call enables
  input  wire logic [6:0] sub_addr1_i,     // Sub-call address 1
  input  wire logic [6:0] sub_addr2_i,     // Sub-call address 2
  input  wire logic [6:0] sub_addr3_i,     // Sub-call address 3
  input  wire logic [7:0] rd_data_i,       // Register file read data
  output logic      [4:0] reg_ptr_o,       // Register being accessed
  output logic            wr_stb_o,        // One-cycle write strobe
  output logic      [7:0] wr_data_o,       // Write data
  output logic            rd_stb_o,        // One-cycle read strobe
  output logic            soft_reset_o     // One-cycle soft reset
);

  // Link domain state
  logic [1:0]    bus_s;
  logic          scl_s;
  logic          sda_s;
  logic          scl_p_q;
  logic          sda_p_q;
  logic          start_w;
  logic          stop_w;
  logic          rise_w;
  logic          fall_w;
  itrp_link_st_t st_q;
  itrp_phase_t   phase_q;
  itrp_srst_t    srst_q;
  logic [3:0]    cnt_q;
  logic [7:0]    shift_q;
  logic [7:0]    tx_q;
  logic          rw_q;
  logic          ackd_q;
  logic          mack_q;
  logic          ack_w;
  logic [7:0]    ctrl_q;
  logic [4:0]    ptr_nx;
  logic [4:0]    ev_ptr_q;
  logic [7:0]    wr_byte_q;
  logic          wr_tgl_q;
  logic          fetch_tgl_q;
  logic          srst_tgl_q;
  logic          rdack_s;
  logic          rdack_p_q;
  logic [7:0]    rd_word_q;
  logic          byte_end_w;
  logic          sda_oen_q;

  // Configuration seen from the link side
  logic [35:0]   cfg_s;
  logic [3:0]    pins_s;
  logic          grp_en_s;
  logic [6:0]    all_s;
  logic [2:0]    sub_en_s;
  logic [6:0]    sub_s [3];
  logic [2:0]    sub_hit;
  logic [6:0]    addr_w;
  logic          own_hit;
  logic          all_hit;
  logic          srst_hit;
  logic          match_w;

  // System domain state
  logic [2:0]    ev_s;
  logic [2:0]    ev_p_q;
  logic          fetch_pend_q;
  logic [7:0]    rd_hold_q;
  logic          rdack_tgl_q;

  // Bus lines are foreign to both clocks; idle-high reset avoids a
  // false START right after reset
  itrp_sync #(.W(2), .RST_VAL(BUS_IDLE)) u_bus_sync (
    .clk_i  (link_clk_i),
    .rstn_i (rstn_i),
    .d_i    ({scl_i, sda_i}),
    .q_o    (bus_s)
  );
  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];

  // Straps and address registers are quasi-static; they are only
  // compared at the end of an address byte
  itrp_sync #(.W(36), .RST_VAL(36'h0)) u_cfg_sync (
    .clk_i  (link_clk_i),
    .rstn_i (rstn_i),
    .d_i    ({addr_pins_i, group_call_enable_i, group_call_addr_i,
              sub_enable_i, sub_addr1_i, sub_addr2_i, sub_addr3_i}),
    .q_o    (cfg_s)
  );
  assign pins_s   = cfg_s[35:32];
  assign grp_en_s = cfg_s[31];
  assign all_s    = cfg_s[30:24];
  assign sub_en_s = cfg_s[23:21];
  assign sub_s[0] = cfg_s[20:14];
  assign sub_s[1] = cfg_s[13:7];
  assign sub_s[2] = cfg_s[6:0];

  // Previous line levels for edge and condition detection
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Conditions need the clock high in both samples
  assign start_w = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_w  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign rise_w  = scl_s & ~scl_p_q;
  assign fall_w  = ~scl_s & scl_p_q;
  assign byte_end_w = (st_q == ST_RX) && fall_w && (cnt_q == BIT_CNT_LAST);

  // Address matching; the reserved address is excluded everywhere
  assign addr_w   = shift_q[7:1];
  assign own_hit  = (addr_w == {OWN_ADDR_HI, pins_s}) &&
                    (addr_w != SRST_ADDR);
  assign all_hit  = grp_en_s && (addr_w == all_s) &&
                    (addr_w != SRST_ADDR);
  assign srst_hit = (addr_w == SRST_ADDR) && !shift_q[0];

  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_sub
      assign sub_hit[k] = sub_en_s[k] && (addr_w == sub_s[k]) &&
                          (addr_w != SRST_ADDR);
    end
  endgenerate

  assign match_w = own_hit | all_hit | (|sub_hit);

  // Acknowledge decision for the byte just received
  always_comb begin
    ack_w = 1'b0;
    if (phase_q == PH_ADDR) begin
      ack_w = match_w | srst_hit;
    end else if (srst_q == SR_ADDR) begin
      ack_w = (shift_q == SRST_KEY1);
    end else if (srst_q == SR_KEY1) begin
      ack_w = (shift_q == SRST_KEY2);
    end else if (srst_q == SR_ARMED) begin
      ack_w = 1'b0;
    end else begin
      ack_w = 1'b1;
    end
  end

  // Bit engine: receive, acknowledge and transmit
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q      <= ST_IDLE;
      cnt_q     <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      ackd_q    <= 1'b0;
      mack_q    <= 1'b0;
      sda_oen_q <= 1'b1;
    end else if (start_w) begin
      st_q      <= ST_RX;
      cnt_q     <= 4'h0;
      sda_oen_q <= 1'b1;
    end else if (stop_w) begin
      st_q      <= ST_IDLE;
      sda_oen_q <= 1'b1;
    end else begin
      case (st_q)
        ST_RX: begin
          if (rise_w && cnt_q != BIT_CNT_LAST) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q   <= cnt_q + 4'h1;
          end else if (byte_end_w) begin
            st_q      <= ST_RX_ACK;
            ackd_q    <= ack_w;
            sda_oen_q <= ~ack_w;
          end
        end
        ST_RX_ACK: begin
          if (fall_w) begin
            cnt_q <= 4'h0;
            if (!ackd_q) begin
              st_q      <= ST_IDLE;
              sda_oen_q <= 1'b1;
            end else if (phase_q == PH_DATA && rw_q) begin
              st_q      <= ST_TX;
              tx_q      <= rd_word_q;
              sda_oen_q <= rd_word_q[7];
            end else begin
              st_q      <= ST_RX;
              sda_oen_q <= 1'b1;
            end
          end
        end
        ST_TX: begin
          if (fall_w) begin
            if (cnt_q == TX_CNT_LAST) begin
              st_q      <= ST_TX_ACK;
              sda_oen_q <= 1'b1;
            end else begin
              tx_q      <= {tx_q[6:0], 1'b0};
              sda_oen_q <= tx_q[6];
              cnt_q     <= cnt_q + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (rise_w) begin
            mack_q <= ~sda_s;
          end else if (fall_w) begin
            cnt_q <= 4'h0;
            if (mack_q) begin
              st_q      <= ST_TX;
              tx_q      <= rd_word_q;
              sda_oen_q <= rd_word_q[7];
            end else begin
              st_q      <= ST_IDLE;
              sda_oen_q <= 1'b1;
            end
          end
        end
        default: begin
          st_q      <= ST_IDLE;
          sda_oen_q <= 1'b1;
        end
      endcase
    end
  end

  assign sda_oen_o = sda_oen_q;

  // Open-drain: the value is always low, only the enable moves
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // Pointer successor for the current option code
  itrp_ptr_next u_ptr_next (
    .code_i (ctrl_q[CTRL_CODE_HI:CTRL_CODE_LO]),
    .ptr_i  (ctrl_q[CTRL_PTR_HI:CTRL_PTR_LO]),
    .ptr_o  (ptr_nx)
  );

  // Byte decode: phase, control byte, pointer and events
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_q     <= PH_ADDR;
      rw_q        <= 1'b0;
      ctrl_q      <= CTRL_RST;
      ev_ptr_q    <= PTR_FIRST;
      wr_byte_q   <= 8'h00;
      wr_tgl_q    <= 1'b0;
      fetch_tgl_q <= 1'b0;
    end else if (start_w) begin
      phase_q <= PH_ADDR;
    end else if (stop_w) begin
      phase_q <= PH_ADDR;
      if (srst_q == SR_ARMED) begin
        ctrl_q <= CTRL_RST;
      end
    end else if (byte_end_w && ack_w) begin
      case (phase_q)
        PH_ADDR: begin
          rw_q <= shift_q[0];
          if (shift_q[0]) begin
            phase_q     <= PH_DATA;
            ev_ptr_q    <= ctrl_q[CTRL_PTR_HI:CTRL_PTR_LO];
            fetch_tgl_q <= ~fetch_tgl_q;
          end else begin
            phase_q <= PH_CTRL;
          end
        end
        PH_CTRL: begin
          if (srst_q == SR_NONE) begin
            ctrl_q  <= shift_q;
            phase_q <= PH_DATA;
          end
        end
        default: begin
          ev_ptr_q  <= ctrl_q[CTRL_PTR_HI:CTRL_PTR_LO];
          wr_byte_q <= shift_q;
          wr_tgl_q  <= ~wr_tgl_q;
          ctrl_q[CTRL_PTR_HI:CTRL_PTR_LO] <= ptr_nx;
        end
      endcase
    end else if (st_q == ST_TX_ACK && rise_w) begin
      ctrl_q[CTRL_PTR_HI:CTRL_PTR_LO] <= ptr_nx;
      ev_ptr_q <= ptr_nx;
      if (!sda_s) begin
        fetch_tgl_q <= ~fetch_tgl_q;
      end
    end
  end

  // Soft-reset sequence tracking; any refused byte aborts the call
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      srst_q     <= SR_NONE;
      srst_tgl_q <= 1'b0;
    end else if (start_w) begin
      srst_q <= SR_NONE;
    end else if (stop_w) begin
      srst_q <= SR_NONE;
      if (srst_q == SR_ARMED) begin
        srst_tgl_q <= ~srst_tgl_q;
      end
    end else if (byte_end_w) begin
      if (phase_q == PH_ADDR) begin
        srst_q <= srst_hit ? SR_ADDR : SR_NONE;
      end else if (!ack_w) begin
        srst_q <= SR_NONE;
      end else if (srst_q == SR_ADDR) begin
        srst_q <= SR_KEY1;
      end else if (srst_q == SR_KEY1) begin
        srst_q <= SR_ARMED;
      end
    end
  end

  // Read word comes back by handshake; hold is stable on the toggle
  itrp_sync #(.W(1), .RST_VAL(1'b0)) u_rdack_sync (
    .clk_i  (link_clk_i),
    .rstn_i (rstn_i),
    .d_i    (rdack_tgl_q),
    .q_o    (rdack_s)
  );

  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdack_p_q <= 1'b0;
      rd_word_q <= 8'h00;
    end else begin
      rdack_p_q <= rdack_s;
      if (rdack_s != rdack_p_q) begin
        rd_word_q <= rd_hold_q;
      end
    end
  end

  // Event toggles into the system domain
  itrp_sync #(.W(3), .RST_VAL(3'h0)) u_ev_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({srst_tgl_q, fetch_tgl_q, wr_tgl_q}),
    .q_o    (ev_s)
  );

  // Strobes and pointer toward the register file; payload was
  // frozen on the link side on the same clock edge that moved its toggle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ev_p_q       <= 3'h0;
      reg_ptr_o    <= PTR_FIRST;
      wr_stb_o     <= 1'b0;
      wr_data_o    <= 8'h00;
      rd_stb_o     <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      ev_p_q       <= ev_s;
      wr_stb_o     <= ev_s[0] ^ ev_p_q[0];
      rd_stb_o     <= ev_s[1] ^ ev_p_q[1];
      soft_reset_o <= ev_s[2] ^ ev_p_q[2];
      if ((ev_s[0] ^ ev_p_q[0]) || (ev_s[1] ^ ev_p_q[1])) begin
        reg_ptr_o <= ev_ptr_q;
      end
      if (ev_s[0] ^ ev_p_q[0]) begin
        wr_data_o <= wr_byte_q;
      end
    end
  end

  // Capture read data one cycle after the read strobe, then answer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fetch_pend_q <= 1'b0;
      rd_hold_q    <= 8'h00;
      rdack_tgl_q  <= 1'b0;
    end else begin
      fetch_pend_q <= rd_stb_o;
      if (fetch_pend_q) begin
        rd_hold_q   <= rd_data_i;
        rdack_tgl_q <= ~rdack_tgl_q;
      end
    end
  end

endmodule : itrp_i2c_target

/* tb/itrp_i2c_target_monitor.sv */
`timescale 1ns/10ps
module itrp_i2c_target_monitor
  import itrp_pkg::*;
(
  input wire logic       clk_i,        // System clock
  input wire logic       rstn_i,       // Reset, active low
  input wire logic       link_clk_i,   // Link clock
  input wire logic       scl_i,        // Bus clock line
  input wire logic       sda_i,        // Bus data line
  input wire logic       sda_o,        // Drive value
  input wire logic       sda_oen_o,    // Drive enable, low=drive
  input wire logic [4:0] reg_ptr_o,    // Register pointer
  input wire logic       wr_stb_o,     // Write strobe
  input wire logic [7:0] wr_data_o,    // Write data
  input wire logic       rd_stb_o,     // Read strobe
  input wire logic       soft_reset_o  // Soft reset pulse
);
  // Link side: only pulls low, never moves the line while SCL is high
  property p_drv_low; @(posedge link_clk_i) disable iff (!rstn_i)
    sda_o == 1'b0; endproperty
  a_drv_low: assert property (p_drv_low)
    else $error("data drive value not low");
  property p_ack_hold; @(posedge link_clk_i) disable iff (!rstn_i)
    (scl_i && !sda_oen_o) |=> (!sda_oen_o || !scl_i); endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("data released while clock high");
  property p_no_grab; @(posedge link_clk_i) disable iff (!rstn_i)
    (scl_i && sda_oen_o) |=> (sda_oen_o || !scl_i); endproperty
  a_no_grab: assert property (p_no_grab)
    else $error("data pulled while clock high");
  // Register side: one-cycle pulses, at least eight system clocks apart
  property p_wr_gap; @(posedge clk_i) disable iff (!rstn_i)
    wr_stb_o |=> !(wr_stb_o || rd_stb_o) [*8]; endproperty
  a_wr_gap: assert property (p_wr_gap)
    else $error("write strobe too long or too close");
  property p_rd_gap; @(posedge clk_i) disable iff (!rstn_i)
    rd_stb_o |=> !(wr_stb_o || rd_stb_o) [*8]; endproperty
  a_rd_gap: assert property (p_rd_gap)
    else $error("read strobe too long or too close");
  property p_srst_stop; @(posedge clk_i) disable iff (!rstn_i)
    soft_reset_o |-> (scl_i && sda_i) ##1 !soft_reset_o; endproperty
  a_srst_stop: assert property (p_srst_stop)
    else $error("soft reset outside a stopped bus");
  property p_ptr_range; @(posedge clk_i) disable iff (!rstn_i)
    (wr_stb_o || rd_stb_o) |-> reg_ptr_o <= PTR_LAST; endproperty
  a_ptr_range: assert property (p_ptr_range)
    else $error("pointer beyond last register");
  property p_ptr_hold; @(posedge clk_i) disable iff (!rstn_i)
    !$stable(reg_ptr_o) |-> (wr_stb_o || rd_stb_o); endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer moved without a strobe");
  property p_data_hold; @(posedge clk_i) disable iff (!rstn_i)
    !$stable(wr_data_o) |-> wr_stb_o; endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("write data moved without a strobe");
  c_wr: cover property (@(posedge clk_i) wr_stb_o);
  c_rd: cover property (@(posedge clk_i) rd_stb_o);
  c_srst: cover property (@(posedge clk_i) soft_reset_o);
endmodule : itrp_i2c_target_monitor

bind itrp_i2c_target itrp_i2c_target_monitor i_mon (
  .clk_i(clk_i), .rstn_i(rstn_i), .link_clk_i(link_clk_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oen_o(sda_oen_o),
  .reg_ptr_o(reg_ptr_o), .wr_stb_o(wr_stb_o), .wr_data_o(wr_data_o),
  .rd_stb_o(rd_stb_o), .soft_reset_o(soft_reset_o));

/* tb/itrp_i2c_master_model.sv */
`timescale 1ns/10ps
module itrp_i2c_master_model (
  output logic      scl_o,     // Bus clock line
  output logic      sda_oen_o, // Data enable, low=pull low
  input  wire logic sda_i      // Resolved data line
);
  localparam int H = 500; // Half bit, 1 MHz bus

  // Both lines released until a frame begins
  initial begin
    scl_o = 1'b1;
    sda_oen_o = 1'b1;
  end

  // Waits for a free bus, then data falls under a high clock
  task start;
    wait (scl_o && sda_i);
    #H sda_oen_o = 1'b0;
    #H scl_o = 1'b0;
  endtask : start

  // Data only moves in the low phase, sampled mid high phase
  task bit_x(input logic b, output logic r);
    #(H/2) sda_oen_o = b;
    #(H/2) scl_o = 1'b1;
    #(H/2) r = sda_i;
    #(H/2) scl_o = 1'b0;
  endtask : bit_x

  task wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask : wr

  // Acknowledges every byte but the last one
  task rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask : rd

  // rel shows whether the target had let go of the line
  task stop(output logic rel);
    #(H/2) rel = sda_i;
    sda_oen_o = 1'b0;
    #(H/2) scl_o = 1'b1;
    #H sda_oen_o = 1'b1;
    #H;
  endtask : stop
endmodule : itrp_i2c_master_model

/* tb/itrp_i2c_target_test.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  err_total++; $display("mismatch %s expected %0h seen %0h", n, e, a); \
  end end
module itrp_i2c_target_test;
  import itrp_pkg::*;
  logic        clk_i, link_clk, rstn, scl, m_oen, dut_oen, dut_sda, gce;
  logic        wr_stb, rd_stb, srst;
  logic [2:0]  sube;
  logic [3:0]  pins;
  logic [4:0]  ptr;
  logic [6:0]  allc, s1, s2, s3;
  logic [7:0]  rdat, wdat;
  logic [12:0] wq[$];
  logic [4:0]  rq[$];
  int          err_total, samples_checked, nrst;
  wire         sda = m_oen & (dut_oen | dut_sda); // Pulled-up line

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Free-running link clock, offset by 7 ns; its edges still meet clk_i edges, first at 55 ns
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  itrp_i2c_master_model i_mst (.scl_o(scl), .sda_oen_o(m_oen), .sda_i(sda));
  itrp_i2c_target i_dut (
    .clk_i(clk_i), .rstn_i(rstn), .link_clk_i(link_clk), .scl_i(scl),
    .sda_i(sda), .sda_o(dut_sda), .sda_oen_o(dut_oen), .addr_pins_i(pins),
    .group_call_enable_i(gce), .group_call_addr_i(allc), .sub_enable_i(sube),
    .sub_addr1_i(s1), .sub_addr2_i(s2), .sub_addr3_i(s3), .rd_data_i(rdat),
    .reg_ptr_o(ptr), .wr_stb_o(wr_stb), .wr_data_o(wdat),
    .rd_stb_o(rd_stb), .soft_reset_o(srst));

  // Register file stand-in: logs strobes, data tells its own pointer
  always @(posedge clk_i) begin
    if (wr_stb) wq.push_back({ptr, wdat});
    if (rd_stb) rq.push_back(ptr);
    if (srst) nrst++;
  end
  always @(negedge clk_i) rdat <= {3'h5, ptr};

  // Expected pointer after an access
  function automatic logic [4:0] nxt(input logic [7:0] c,
                                     input logic [4:0] p);
    logic [4:0] lim, lo;
    if (!c[7]) return p;
    lim = (c[6:5] == 2'h0) ? PTR_LAST :
          (c[6:5] == 2'h1) ? PTR_BRIGHT_HI : PTR_GLOBAL_HI;
    lo = (c[6:5] == 2'h0) ? PTR_FIRST :
         (c[6:5] == 2'h2) ? PTR_GLOBAL_LO : PTR_BRIGHT_LO;
    if (p == lim) return lo;
    return (p == PTR_LAST) ? PTR_FIRST : p + 5'h01;
  endfunction : nxt

  task wb(input logic [7:0] d);
    logic k;
    i_mst.wr(d, k);
    `CHK("ack", 1'b1, k)
  endtask : wb

  // Own, group and sub-call hits; reserved address never matches
  task t_addr;
    logic [8:0] tab[6];
    logic k, r;
    tab = '{9'h1CA, 9'h0CC, 9'h1D0, 9'h1E0, 9'h0D8, 9'h0D7};
    @(negedge clk_i);
    sube = 3'h3;
    for (int i = 0; i < 6; i++) begin
      i_mst.start;
      i_mst.wr(tab[i][7:0], k);
      `CHK("addr ack", tab[i][8], k)
      i_mst.stop(r);
    end
    @(negedge clk_i);
    gce = 1'b0;
    i_mst.start;
    i_mst.wr(8'hD0, k);
    `CHK("group off", 1'b0, k)
    i_mst.stop(r);
  endtask : t_addr

  // Every legal option code; each walking option crosses its wrap point
  task t_modes;
    logic [7:0] tab[6];
    logic [4:0] p;
    logic r;
    tab = '{8'h05, 8'h9A, 8'hB0, 8'hD2, 8'hF3, 8'hBA};
    for (int i = 0; i < 6; i++) begin
      wq.delete();
      i_mst.start;
      wb(8'hCA);
      wb(tab[i]);
      for (int j = 0; j < 3; j++) wb({i[3:0], j[3:0]});
      i_mst.stop(r);
      p = tab[i][4:0];
      `CHK("wr count", 3, wq.size())
      for (int j = 0; j < 3; j++) begin
        `CHK("write", {p, i[3:0], j[3:0]}, wq[j])
        p = nxt(tab[i], p);
      end
    end
  endtask : t_modes

  // Read across the last register, ending with a refused byte
  task t_read;
    logic [7:0] d;
    logic r;
    i_mst.start;
    wb(8'hCA);
    wb(8'h9B);
    i_mst.stop(r);
    rq.delete();
    i_mst.start;
    wb(8'hCB);
    i_mst.rd(1'b0, d);
    `CHK("rd byte", 8'hBB, d)
    i_mst.rd(1'b1, d);
    `CHK("rd byte", 8'hA0, d)
    i_mst.stop(r);
    `CHK("released", 1'b1, r)
    `CHK("fetches", 2, rq.size())
  endtask : t_read

  // Bad key aborts; good keys reset and clear the control byte
  task t_srst;
    logic [7:0] d;
    logic k, r;
    i_mst.start;
    wb(8'hD6);
    i_mst.wr(8'h00, k);
    `CHK("key ack", 1'b0, k)
    i_mst.stop(r);
    `CHK("resets", 0, nrst)
    i_mst.start;
    wb({SRST_ADDR, 1'b0});
    wb(SRST_KEY1);
    wb(SRST_KEY2);
    i_mst.stop(r);
    `CHK("resets", 1, nrst)
    rq.delete();
    i_mst.start;
    wb(8'hCB);
    i_mst.rd(1'b0, d);
    i_mst.rd(1'b1, d);
    i_mst.stop(r);
    `CHK("rd byte", 8'hA0, d)
    `CHK("fetch ptr", 5'h00, rq[1])
  endtask : t_srst

  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Reset spans two link clocks so both domains see it
  initial begin
    rstn = 1'b0;
    pins = 4'h5;
    gce = 1'b1;
    allc = 7'h68;
    sube = 3'h0;
    s1 = SRST_ADDR;
    s2 = 7'h70;
    s3 = 7'h6C;
    repeat (2) @(posedge link_clk);
    @(negedge clk_i);
    rstn = 1'b1;
    repeat (4) @(posedge link_clk);
    t_addr;
    t_modes;
    t_read;
    t_srst;
    tally_and_finish;
  end

  // Whole run needs about 0.5 ms of bus time
  initial begin
    #800000;
    err_total++;
    tally_and_finish;
  end
endmodule : itrp_i2c_target_test
